//--- design/krlts_pkg.sv
package krlts_pkg;
  // Word indices; byte address is four times the index
  localparam logic [11:0] KRLTS_IDX_PARTNER   = 12'h4D4;
  localparam logic [11:0] KRLTS_IDX_TRAINED   = 12'h4D5;
  localparam logic [11:0] KRLTS_IDX_OVERRIDE  = 12'h4D6;
  localparam logic [11:0] KRLTS_IDX_RSV_LAST  = 12'h4FF;

  // Partner status word fields
  localparam int KRLTS_PCS_LSB       = 24;
  localparam int KRLTS_PRX_BIT       = 30;
  // Trained settings word fields
  localparam int KRLTS_SWING_LSB     = 0;
  localparam int KRLTS_POST_LSB      = 8;
  localparam int KRLTS_PRE_LSB       = 16;
  localparam int KRLTS_RC_LSB        = 24;
  localparam int KRLTS_LMODE_LSB     = 28;
  localparam int KRLTS_FMODE_LSB     = 30;
  // Override word fields
  localparam int KRLTS_MAXV_LSB      = 0;
  localparam int KRLTS_MAXE_BIT      = 5;
  localparam int KRLTS_MINV_LSB      = 8;
  localparam int KRLTS_MINE_BIT      = 13;
  localparam int KRLTS_POSTV_LSB     = 16;
  localparam int KRLTS_POSTE_BIT     = 22;
  localparam int KRLTS_PREV_LSB      = 24;
  localparam int KRLTS_PREE_BIT      = 29;
  localparam logic [31:0] KRLTS_OVR_MASK  = 32'h3F7F3F3F;
  localparam logic [31:0] KRLTS_OVR_RESET = 32'h00000000;

  // Coefficient status encoding
  localparam logic [1:0] KRLTS_CS_NOT_UPDATED = 2'h0;
  localparam logic [1:0] KRLTS_CS_MINIMUM     = 2'h1;
  localparam logic [1:0] KRLTS_CS_UPDATED     = 2'h2;
  localparam logic [1:0] KRLTS_CS_MAXIMUM     = 2'h3;

  typedef struct packed {
    logic [1:0] plus_one;
    logic [1:0] zero;
    logic [1:0] minus_one;
  } krlts_coeff_report_t;

  typedef struct packed {
    logic [4:0] swing;
    logic [5:0] post;
    logic [4:0] pre;
  } krlts_tx_taps_t;

  typedef struct packed {
    logic [3:0] rc;
    logic [1:0] lin_mode;
    logic [1:0] fb_mode;
  } krlts_rx_eq_t;

  typedef struct packed {
    logic [4:0] max_swing;
    logic [4:0] min_swing;
    logic [4:0] preset_main;
    logic [5:0] post_limit;
    logic [4:0] pre_limit;
  } krlts_limits_t;
endpackage

//--- design/krlts_regs.sv
// Operation
// - Partner status word bits 29:24 show the last frame's second word, read-only.
// - Field holds plus-one status in 5:4, zero in 3:2, minus-one in 1:0.
// - Status codes: 11 maximum, 01 minimum, 10 updated, 00 not updated.
// - Bit 30 reads 1 when partner receiver finished training, else 0.
// - Settings word bits 4:0 hold the latest trained transmit swing.
// - Settings word bits 13:8 hold the latest trained post-cursor tap.
// - Settings word bits 20:16 hold the latest trained pre-cursor tap.
// - Settings word bits 27:24 capture the last linear equaliser RC value sent.
// - Settings word bits 29:28 capture the last linear equaliser mode sent.
// - Settings word bits 31:30 capture the last feedback equaliser mode sent.
// - Override bit 5 set replaces maximum swing rule with bits 4:0.
// - Enabled maximum swing override also replaces the preset main tap.
// - Override bit 13 set replaces minimum swing rule with bits 12:8.
// - Override bit 22 set replaces post-cursor limit with bits 21:16.
// - Override bit 29 set replaces pre-cursor limit with bits 28:24.
// - Words after the override word up to 0x4FF are reserved and unused.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module krlts_regs
  import krlts_pkg::*;
#(
  parameter logic [4:0] MAX_SWING_RULE   = 5'h1F,
  parameter logic [4:0] MIN_SWING_RULE   = 5'h00,
  parameter logic [4:0] PRESET_MAIN_TAP  = 5'h1F,
  parameter logic [5:0] POST_CURSOR_RULE = 6'h3F,
  parameter logic [4:0] PRE_CURSOR_RULE  = 5'h1F
) (
  input  wire logic                clock,          // 25 MHz clock
  input  wire logic                rst_n,          // Async reset, active low
  input  wire logic                psel,           // APB select
  input  wire logic                penable,        // APB access phase
  input  wire logic                pwrite,         // APB write
  input  wire logic [13:0]         paddr,          // APB byte address
  input  wire logic [31:0]         pwdata,         // APB write data
  input  wire logic [3:0]          pstrb,          // APB byte strobes
  output logic                     pready,         // APB ready
  output logic [31:0]              prdata,         // APB read data
  output logic                     pslverr,        // APB error
  input  wire krlts_coeff_report_t partner_coeff_report, // From received frame
  input  wire logic                partner_rx_trained,   // Partner receiver ready
  input  wire logic                frame_valid,    // New partner status this cycle
  input  wire krlts_tx_taps_t      trained_taps,   // Trained transmit settings
  input  wire logic                taps_valid,     // Trained settings update strobe
  input  wire krlts_rx_eq_t        rx_eq_sent,     // Equaliser values to reconfig
  input  wire logic                rx_eq_valid,    // Equaliser send strobe
  output krlts_limits_t            limits          // Effective transmit limits
);

  krlts_coeff_report_t pcs_r, pcs_nxt;
  logic                prx_r, prx_nxt;
  krlts_tx_taps_t      taps_r, taps_nxt;
  krlts_rx_eq_t        eq_r, eq_nxt;
  logic [31:0]         ovr_r, ovr_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  krlts_limits_t       lim_r, lim_nxt;

  logic [11:0] word_idx;
  logic        access;
  logic [31:0] strb_mask;

  function automatic logic [31:0] strb_expand(input logic [3:0] s);
    strb_expand = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Lanes outside the mask keep their old contents
  function automatic logic [31:0] merge_word(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [31:0] mask);
    merge_word = (old_word & ~mask) | (new_word & mask);
  endfunction

  // Enabled override replaces the built-in value
  function automatic logic [4:0] pick5(input logic       on,
                                       input logic [4:0] ovr_val,
                                       input logic [4:0] rule_val);
    if (on) begin
      pick5 = ovr_val;
    end else begin
      pick5 = rule_val;
    end
  endfunction

  function automatic logic [5:0] pick6(input logic       on,
                                       input logic [5:0] ovr_val,
                                       input logic [5:0] rule_val);
    if (on) begin
      pick6 = ovr_val;
    end else begin
      pick6 = rule_val;
    end
  endfunction

  // One place assembles every readable word
  function automatic logic [31:0] read_word(input logic [11:0]         idx,
                                            input krlts_coeff_report_t pcs,
                                            input logic                prx,
                                            input krlts_tx_taps_t      taps,
                                            input krlts_rx_eq_t        eq,
                                            input logic [31:0]         ovr);
    logic [31:0] w;
    w = 32'h00000000;
    case (idx)
      KRLTS_IDX_PARTNER: begin
        w[KRLTS_PCS_LSB +: 6] = pcs;
        w[KRLTS_PRX_BIT] = prx;
      end
      KRLTS_IDX_TRAINED: begin
        w[KRLTS_SWING_LSB +: 5] = taps.swing;
        w[KRLTS_POST_LSB +: 6] = taps.post;
        w[KRLTS_PRE_LSB +: 5] = taps.pre;
        w[KRLTS_RC_LSB +: 4] = eq.rc;
        w[KRLTS_LMODE_LSB +: 2] = eq.lin_mode;
        w[KRLTS_FMODE_LSB +: 2] = eq.fb_mode;
      end
      KRLTS_IDX_OVERRIDE: begin
        w = ovr & KRLTS_OVR_MASK;
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    read_word = w;
  endfunction

  assign word_idx  = paddr[13:2];
  assign access    = psel && penable;
  assign strb_mask = strb_expand(pstrb);
  // Zero wait states keep the master simple
  assign pready    = 1'b1;
  assign prdata    = rdata_r;
  // Reserved and foreign words read zero, so no error answer exists
  assign pslverr   = 1'b0;
  assign limits    = lim_r;

  // Partner status group
  always_comb begin
    pcs_nxt = pcs_r;
    prx_nxt = prx_r;
    if (frame_valid) begin
      pcs_nxt = partner_coeff_report;
      prx_nxt = partner_rx_trained;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pcs_r <= '0;
      prx_r <= 1'b0;
    end else begin
      pcs_r <= pcs_nxt;
      prx_r <= prx_nxt;
    end
  end

  // Trained transmit settings group
  always_comb begin
    taps_nxt = taps_r;
    if (taps_valid) begin
      taps_nxt = trained_taps;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      taps_r <= '0;
    end else begin
      taps_r <= taps_nxt;
    end
  end

  // Receive equaliser group
  always_comb begin
    eq_nxt = eq_r;
    if (rx_eq_valid) begin
      eq_nxt = rx_eq_sent;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eq_r <= '0;
    end else begin
      eq_r <= eq_nxt;
    end
  end

  // Override group; status words ignore writes
  always_comb begin
    ovr_nxt = ovr_r;
    if (access && pwrite && word_idx == KRLTS_IDX_OVERRIDE) begin
      ovr_nxt = merge_word(ovr_r, pwdata, strb_mask) & KRLTS_OVR_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ovr_r <= KRLTS_OVR_RESET;
    end else begin
      ovr_r <= ovr_nxt;
    end
  end

  // Setup cycle prepares read data so it is a flop by the access edge
  always_comb begin
    rdata_nxt = rdata_r;
    if (psel && !penable && !pwrite) begin
      rdata_nxt = read_word(word_idx, pcs_r, prx_r, taps_r, eq_r, ovr_r);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Limits lag the override word by one cycle
  always_comb begin
    lim_nxt.max_swing   = pick5(ovr_r[KRLTS_MAXE_BIT], ovr_r[KRLTS_MAXV_LSB +: 5], MAX_SWING_RULE);
    lim_nxt.preset_main = pick5(ovr_r[KRLTS_MAXE_BIT], ovr_r[KRLTS_MAXV_LSB +: 5], PRESET_MAIN_TAP);
    lim_nxt.min_swing   = pick5(ovr_r[KRLTS_MINE_BIT], ovr_r[KRLTS_MINV_LSB +: 5], MIN_SWING_RULE);
    lim_nxt.post_limit  = pick6(ovr_r[KRLTS_POSTE_BIT], ovr_r[KRLTS_POSTV_LSB +: 6], POST_CURSOR_RULE);
    lim_nxt.pre_limit   = pick5(ovr_r[KRLTS_PREE_BIT], ovr_r[KRLTS_PREV_LSB +: 5], PRE_CURSOR_RULE);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lim_r <= '0;
    end else begin
      lim_r <= lim_nxt;
    end
  end

endmodule // krlts_regs

//--- dv/krlts_apb_master.sv
`timescale 1ns/100ps
module krlts_apb_master (
  input  wire logic        clock,   // Bus clock
  input  wire logic        pready,  // Slave ready
  input  wire logic [31:0] prdata,  // Read data
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction
  output logic [13:0]      paddr,   // Byte address
  output logic [31:0]      pwdata,  // Write data
  output logic [3:0]       pstrb,   // Byte strobes
  output logic             hung     // Answer never came
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, hung} = '0;
  end
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung <= (pready !== 1'b1);
    q = prdata;
    // Released data no longer shows the old word
    {psel, penable, pwdata} <= {2'b00, ~d};
  endtask
endmodule // krlts_apb_master

//--- dv/krlts_props.sv
`timescale 1ns/100ps
module krlts_props
  import krlts_pkg::*;
#(
  parameter logic [4:0] MAX_SWING_RULE   = 5'h1F,
  parameter logic [4:0] MIN_SWING_RULE   = 5'h00,
  parameter logic [4:0] PRESET_MAIN_TAP  = 5'h1F,
  parameter logic [5:0] POST_CURSOR_RULE = 6'h3F,
  parameter logic [4:0] PRE_CURSOR_RULE  = 5'h1F
) (
  input wire logic                clock,                // Clock
  input wire logic                rst_n,                // Reset
  input wire logic                psel,                 // Select
  input wire logic                penable,              // Access
  input wire logic                pwrite,               // Direction
  input wire logic [13:0]         paddr,                // Address
  input wire logic [31:0]         pwdata,               // Write data
  input wire logic [3:0]          pstrb,                // Strobes
  input wire logic [31:0]         prdata,               // Read data
  input wire krlts_coeff_report_t partner_coeff_report, // Status
  input wire logic                partner_rx_trained,   // Ready
  input wire logic                frame_valid,          // Strobe
  input wire krlts_limits_t       limits                // Limits
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic wo = psel && penable && pwrite && paddr[13:2] == KRLTS_IDX_OVERRIDE;
  wire logic ra = psel && penable && !pwrite;
  property p_max; wo && pstrb[0] |-> ##2 limits.max_swing == ($past(pwdata[5], 2) ? $past(pwdata[4:0], 2) : MAX_SWING_RULE); endproperty
  a_max: assert property (p_max) else $error("max swing limit wrong");
  property p_pre_main; wo && pstrb[0] |-> ##2 limits.preset_main == ($past(pwdata[5], 2) ? $past(pwdata[4:0], 2) : PRESET_MAIN_TAP); endproperty
  a_pre_main: assert property (p_pre_main) else $error("preset main wrong");
  property p_min; wo && pstrb[1] |-> ##2 limits.min_swing == ($past(pwdata[13], 2) ? $past(pwdata[12:8], 2) : MIN_SWING_RULE); endproperty
  a_min: assert property (p_min) else $error("min swing limit wrong");
  property p_post; wo && pstrb[2] |-> ##2 limits.post_limit == ($past(pwdata[22], 2) ? $past(pwdata[21:16], 2) : POST_CURSOR_RULE); endproperty
  a_post: assert property (p_post) else $error("post limit wrong");
  property p_pre; wo && pstrb[3] |-> ##2 limits.pre_limit == ($past(pwdata[29], 2) ? $past(pwdata[28:24], 2) : PRE_CURSOR_RULE); endproperty
  a_pre: assert property (p_pre) else $error("pre limit wrong");
  property p_zero; ra && paddr[13:2] == KRLTS_IDX_PARTNER |-> prdata[31] == 1'b0 && prdata[23:0] == 24'h000000; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_rsv; ra && paddr[13:2] > KRLTS_IDX_OVERRIDE && paddr[13:2] <= KRLTS_IDX_RSV_LAST |-> prdata == 32'h00000000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved word not zero");
  property p_cap; frame_valid ##1 (psel && !penable && !pwrite && paddr[13:2] == KRLTS_IDX_PARTNER)
    |=> prdata[30:24] == {$past(partner_rx_trained, 2), $past(partner_coeff_report, 2)}; endproperty
  a_cap: assert property (p_cap) else $error("partner status not captured");
endmodule // krlts_props
bind krlts_regs krlts_props #(.MAX_SWING_RULE(MAX_SWING_RULE), .MIN_SWING_RULE(MIN_SWING_RULE),
  .PRESET_MAIN_TAP(PRESET_MAIN_TAP), .POST_CURSOR_RULE(POST_CURSOR_RULE), .PRE_CURSOR_RULE(PRE_CURSOR_RULE))
  krlts_props_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .partner_coeff_report(partner_coeff_report),
  .partner_rx_trained(partner_rx_trained), .frame_valid(frame_valid), .limits(limits));

//--- dv/test_kr_link_training_status_override.sv
`timescale 1ns/100ps
module test_kr_link_training_status_override
  import krlts_pkg::*;
;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, hung, frame_valid, partner_rx_trained;
  logic taps_valid, rx_eq_valid;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, q, d, ovr;
  logic [3:0] pstrb, s;
  logic [5:0] rep;
  krlts_coeff_report_t partner_coeff_report;
  krlts_tx_taps_t trained_taps, tt;
  krlts_rx_eq_t rx_eq_sent, re;
  krlts_limits_t limits;
  int n_fail = 0;
  int n_tests = 0;
  localparam logic [13:0] RO_ADDR [5] = '{14'h1350, 14'h1354, 14'h1360, 14'h13FC, 14'h0000};
  // Distinct defaults so a swapped limit shows
  krlts_regs #(.MAX_SWING_RULE(5'h1C), .MIN_SWING_RULE(5'h02), .PRESET_MAIN_TAP(5'h15), .POST_CURSOR_RULE(6'h30),
    .PRE_CURSOR_RULE(5'h0C)) krlts_regs_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .partner_coeff_report(partner_coeff_report), .partner_rx_trained(partner_rx_trained),
    .frame_valid(frame_valid), .trained_taps(trained_taps), .taps_valid(taps_valid), .rx_eq_sent(rx_eq_sent),
    .rx_eq_valid(rx_eq_valid), .limits(limits));
  krlts_apb_master krlts_apb_master_i (.clock(clock), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .hung(hung));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic krlts_limits_t lim(input logic [31:0] o);
    return {o[5] ? o[4:0] : 5'h1C, o[13] ? o[12:8] : 5'h02, o[5] ? o[4:0] : 5'h15, o[22] ? o[21:16] : 6'h30,
            o[29] ? o[28:24] : 5'h0C};
  endfunction
  // Initial taps taken as 10 hex here; each override stays on the side software must keep
  function automatic logic [31:0] sw_ovr(input logic [31:0] r);
    return {r[31:29], 5'h11 | 5'(r[27:24]), r[23:22], 6'h11 | 6'(r[19:16]), r[15:13], 5'h04 + 5'(r[10:8]),
            r[7:5], 5'h11 | 5'(r[3:0])};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge hung) begin
    $display("unexpected at %0t: no answer on the bus", $time);
    n_fail++;
    end_sim();
  end
  initial begin
    {rst_n, frame_valid, taps_valid, rx_eq_valid, partner_rx_trained} = '0;
    {partner_coeff_report, trained_taps, rx_eq_sent, ovr} = '0;
    void'($urandom(88797));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      s = (i < 2) ? 4'hF : 4'($urandom);
      d = (i == 0) ? 32'h3E7E233E : (i == 1) ? 32'h00000000 : sw_ovr($urandom);
      krlts_apb_master_i.xfer(1'b1, 14'h1358, d, s, q);
      ovr = (ovr & ~{{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}}) | (d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & KRLTS_OVR_MASK);
      repeat (2) @(posedge clock);
      chk(32'(limits), 32'(lim(ovr)));
      krlts_apb_master_i.xfer(1'b0, 14'h1358, 32'h0, 4'h0, q);
      chk(q, ovr);
    end
    $display("override test done");
    // Mid-run reset zeroes every limit; they return to the built-in rules on the first edge after release
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    ovr = '0;
    repeat (2) @(posedge clock);
    chk(32'(limits), 32'(lim(ovr)));
    krlts_apb_master_i.xfer(1'b0, 14'h1358, 32'h0, 4'h0, q);
    chk(q, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      d = 32'(RO_ADDR[i]);
      krlts_apb_master_i.xfer(1'b1, d[13:0], $urandom, 4'hF, q);
      krlts_apb_master_i.xfer(1'b0, d[13:0], 32'h0, 4'h0, q);
      chk(q, 32'h0);
      chk(32'(pslverr), 32'h0);
    end
    $display("read-only test done");
    for (int c = 0; c < 4; c++) begin
      rep = {2'(c), 2'(c + 1), 2'(c + 2)};
      tt = 16'($urandom);
      re = 8'($urandom);
      @(posedge clock);
      {partner_coeff_report, partner_rx_trained, trained_taps, rx_eq_sent} <= {rep, c[0], tt, re};
      {frame_valid, taps_valid, rx_eq_valid} <= 3'b111;
      // Strobes last one cycle and drop on the edge where the read's setup starts
      fork
        krlts_apb_master_i.xfer(1'b0, 14'h1350, 32'h0, 4'h0, q);
        begin
          @(posedge clock);
          {frame_valid, taps_valid, rx_eq_valid} <= 3'b000;
        end
      join
      chk(q, {1'b0, c[0], rep, 24'h0});
      krlts_apb_master_i.xfer(1'b0, 14'h1354, 32'h0, 4'h0, q);
      chk(q, {re.fb_mode, re.lin_mode, re.rc, 3'h0, tt.pre, 2'h0, tt.post, 3'h0, tt.swing});
    end
    $display("status test done");
    end_sim();
  end
endmodule // test_kr_link_training_status_override
